/* frps_dev.sv */
// frps_dev.sv: bridge end of fundamental reset and power management
// assumes perst_n may move at any time; other user inputs are core_clk synchronous
`timescale 1ns/100ps
`include "frps_params.svh"
module frps_dev
  import frps_pkg::*;
(
  // clock and auxiliary power-on reset
  input  wire logic         core_clk,
  input  wire logic         nrst,
  // platform link
  frps_if.dev               plat,
  // function power control
  input  wire logic         d_state_wr,
  input  wire logic [1:0]   d_state_req,
  input  wire logic         aspm_en,
  input  wire logic         link_idle,
  input  wire logic         turn_off_req,
  // sticky state
  input  wire logic         sticky_wr,
  input  wire logic [7:0]   sticky_wdata,
  output logic [7:0]        sticky_rdata,
  // downstream power-event request
  input  wire logic         power_event_request_n,
  // upstream power management message
  output logic              pm_msg_valid,
  input  wire logic         pm_msg_ready,
  // status
  output logic              core_rst_n,
  output logic              pci_rst_n,
  output frps_dstate_t      d_state,
  output frps_lstate_t      link_state,
  output frps_bstate_t      bus_state
);

  // ****************************************
  // reset synchroniser
  // ****************************************
  logic                       arst_n;
  logic [`FRPS_RST_STAGES-1:0] rst_sync_q;
  logic                       pci_rst_q;

  // perst_n gates the async reset directly, so no phase to the clock is assumed
  assign arst_n = nrst & plat.perst_n;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync_q <= '0;
    end else begin
      rst_sync_q <= {rst_sync_q[`FRPS_RST_STAGES-2:0], 1'b1};
    end
  end

  assign core_rst_n = rst_sync_q[`FRPS_RST_STAGES-1];

  // one stage behind the core release, asserted with it
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pci_rst_q <= 1'b0;
    end else begin
      pci_rst_q <= core_rst_n;
    end
  end

  assign pci_rst_n = pci_rst_q;

  // ****************************************
  // function power state
  // ****************************************
  frps_dstate_t d_q;

  always_ff @(posedge core_clk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      d_q <= FRPS_D0;
    end else if (d_state_wr) begin
      // D1 and D2 codes are ignored, state stays put
      if (d_state_req == `FRPS_D0_CODE) begin
        d_q <= FRPS_D0;
      end else if (d_state_req == `FRPS_D3HOT_CODE) begin
        d_q <= FRPS_D3HOT;
      end
    end
  end

  // a function in reset has lost main power as far as software can tell
  assign d_state = core_rst_n ? d_q : FRPS_D3COLD;

  // ****************************************
  // sticky state, auxiliary reset only
  // ****************************************
  logic [7:0] sticky_q;
  logic       pe_q;
  logic       pme_pend_q;
  logic       pe_fall;
  logic       msg_done;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sticky_q <= `FRPS_STICKY_RST;
    end else if (sticky_wr && core_rst_n) begin
      sticky_q <= sticky_wdata;
    end
  end

  assign sticky_rdata = sticky_q;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pe_q <= 1'b1;
    end else begin
      pe_q <= power_event_request_n;
    end
  end

  assign pe_fall  = pe_q & ~power_event_request_n;
  assign msg_done = pm_msg_valid & pm_msg_ready;

  // pending survives the fundamental reset so a wake event is not dropped
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pme_pend_q <= 1'b0;
    end else begin
      pme_pend_q <= pe_fall | (pme_pend_q & ~msg_done);
    end
  end

  // ****************************************
  // link power state
  // ****************************************
  frps_lstate_t link_q;
  logic [15:0]  idle_cnt_q;
  logic         low_pwr;

  always_ff @(posedge core_clk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      idle_cnt_q <= '0;
    end else if (!link_idle || pme_pend_q || link_q != FRPS_L0 && link_q != FRPS_L0S) begin
      idle_cnt_q <= '0;
    end else if (idle_cnt_q != `FRPS_L1_IDLE_CYC) begin
      idle_cnt_q <= idle_cnt_q + 16'h0001;
    end
  end

  always_ff @(posedge core_clk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      link_q <= FRPS_L3;
    end else begin
      case (link_q)
        FRPS_L0: begin
          if (d_q == FRPS_D3HOT && turn_off_req) begin
            link_q <= FRPS_L23RDY;
          end else if (aspm_en && idle_cnt_q == `FRPS_L0S_IDLE_CYC) begin
            link_q <= FRPS_L0S;
          end
        end
        FRPS_L0S: begin
          if (!link_idle || pme_pend_q) begin
            link_q <= FRPS_L0;
          end else if (idle_cnt_q == `FRPS_L1_IDLE_CYC) begin
            link_q <= FRPS_L1;
          end
        end
        FRPS_L1: begin
          if (!link_idle || pme_pend_q || !aspm_en) begin
            link_q <= FRPS_L0;
          end
        end
        FRPS_L23RDY: begin
          if (d_q == FRPS_D0) begin
            link_q <= FRPS_L0;
          end else if (!plat.refclk_run) begin
            link_q <= FRPS_L3;
          end
        end
        FRPS_L3: begin
          // training waits for a running reference clock
          if (plat.refclk_run) begin
            link_q <= FRPS_L0;
          end
        end
        default: begin
          link_q <= FRPS_L3;
        end
      endcase
    end
  end

  assign link_state = core_rst_n ? link_q : FRPS_L3;
  assign low_pwr    = !core_rst_n || link_q == FRPS_L23RDY || link_q == FRPS_L3;

  // messages leave only on an active link; L0s/L1 exit on pending above
  assign pm_msg_valid = pme_pend_q & core_rst_n & (link_q == FRPS_L0);

  // ****************************************
  // wake, side band only
  // ****************************************
  logic wake_q;

  // no beacon path exists; wake is the only way out of L2
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wake_q <= 1'b0;
    end else begin
      wake_q <= pme_pend_q & low_pwr;
    end
  end

  assign plat.wake_drv_n = 1'b0;
  assign plat.wake_oe_n  = ~wake_q;

  // ****************************************
  // PCI bus power state
  // ****************************************
  frps_bstate_t bus_q;

  always_ff @(posedge core_clk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      bus_q <= FRPS_B3;
    end else if (d_q == FRPS_D3HOT) begin
      bus_q <= FRPS_B2;
    end else if (link_q == FRPS_L1) begin
      bus_q <= FRPS_B1;
    end else begin
      bus_q <= FRPS_B0;
    end
  end

  assign bus_state = core_rst_n ? bus_q : FRPS_B3;

endmodule : frps_dev

/* frps_params.svh */
// frps_params.svh: constants for the fundamental reset and power sequencer ends
// assumes core_clk of both ends runs at the rate given here
`ifndef FRPS_PARAMS_SVH
`define FRPS_PARAMS_SVH

// ****************************************
// clock
// ****************************************
`define FRPS_CLK_MHZ          200

// ****************************************
// platform timing, in printed units
// ****************************************
`define FRPS_T_PVPERL_MS      100
`define FRPS_T_PERST_CLK_US   100
`define FRPS_T_FAIL_NS        500
// least times round up; these divide exactly
`define FRPS_PVPERL_CYC       (`FRPS_T_PVPERL_MS * 1000 * `FRPS_CLK_MHZ)
`define FRPS_PERST_CLK_CYC    (`FRPS_T_PERST_CLK_US * `FRPS_CLK_MHZ)
// longest time rounds down
`define FRPS_FAIL_CYC         ((`FRPS_T_FAIL_NS * `FRPS_CLK_MHZ) / 1000)

// ****************************************
// device side
// ****************************************
`define FRPS_RST_STAGES       3
`define FRPS_L0S_IDLE_CYC     16'h0040
`define FRPS_L1_IDLE_CYC      16'h0400
`define FRPS_STICKY_RST       8'h00
`define FRPS_D0_CODE          2'h0
`define FRPS_D3HOT_CODE       2'h3

`endif

/* frps_pkg.sv */
// frps_pkg.sv: state types shared by the device end and the platform end
// assumes frps_params.svh sits in the include path
package frps_pkg;

  // ****************************************
  // power states
  // ****************************************
  typedef enum logic [1:0] {
    FRPS_D0     = 2'h0,
    FRPS_D3HOT  = 2'h3,
    FRPS_D3COLD = 2'h2
  } frps_dstate_t;

  typedef enum logic [2:0] {
    FRPS_L0     = 3'h0,
    FRPS_L0S    = 3'h1,
    FRPS_L1     = 3'h3,
    FRPS_L23RDY = 3'h2,
    FRPS_L3     = 3'h6
  } frps_lstate_t;

  typedef enum logic [1:0] {
    FRPS_B0 = 2'h0,
    FRPS_B1 = 2'h1,
    FRPS_B2 = 2'h3,
    FRPS_B3 = 2'h2
  } frps_bstate_t;

  // ****************************************
  // platform sequencer
  // ****************************************
  typedef enum logic [2:0] {
    FRPS_H_OFF     = 3'h0,
    FRPS_H_IO_ON   = 3'h1,
    FRPS_H_CORE_ON = 3'h3,
    FRPS_H_WAIT    = 3'h2,
    FRPS_H_RUN     = 3'h6,
    FRPS_H_DN_RST  = 3'h7,
    FRPS_H_DN_CORE = 3'h5
  } frps_hstate_t;

endpackage : frps_pkg

/* frps_if.sv */
// frps_if.sv: reset, clock-run and wake wires between platform and device
// assumes wake is open drain with a board pull-up, modelled here
`timescale 1ns/100ps
interface frps_if;
  logic perst_n;
  logic refclk_run;
  logic wake_drv_n;
  logic wake_oe_n;
  logic wake_n;

  // pull-up wins unless the device enables its driver
  assign wake_n = wake_oe_n ? 1'b1 : wake_drv_n;

  modport dev (
    input  perst_n,
    input  refclk_run,
    input  wake_n,
    output wake_drv_n,
    output wake_oe_n
  );

  modport host (
    output perst_n,
    output refclk_run,
    input  wake_n
  );
endinterface : frps_if

/* frps_host.sv */
// frps_host.sv: platform end, sequences rails, reference clock and reset
// assumes rail_ok reports all rails in range, synchronous to core_clk
`timescale 1ns/100ps
`include "frps_params.svh"
module frps_host
  import frps_pkg::*;
#(
  parameter int unsigned PVPERL_CYC    = `FRPS_PVPERL_CYC,
  parameter int unsigned PERST_CLK_CYC = `FRPS_PERST_CLK_CYC
)(
  // clock and reset
  input  wire logic  core_clk,
  input  wire logic  nrst,
  // device link
  frps_if.host       dev,
  // rail control
  input  wire logic  power_up_req,
  input  wire logic  power_down_req,
  input  wire logic  rail_ok,
  output logic       io_pwr_en,
  output logic       core_pwr_en,
  // status
  output logic       wake_seen,
  output frps_hstate_t seq_state
);

  // ****************************************
  // sequencer
  // ****************************************
  frps_hstate_t st_q;
  frps_hstate_t st_d;
  logic [31:0]  cnt_q;
  logic         powered;

  // core rail and reference clock share one window, so one decode serves both
  function automatic logic core_up(input frps_hstate_t st);
    return st == FRPS_H_CORE_ON || st == FRPS_H_WAIT || st == FRPS_H_RUN || st == FRPS_H_DN_RST;
  endfunction : core_up

  assign powered = st_q == FRPS_H_CORE_ON || st_q == FRPS_H_WAIT || st_q == FRPS_H_RUN;

  always_comb begin
    st_d = st_q;
    case (st_q)
      FRPS_H_OFF: begin
        if (power_up_req || wake_seen) begin
          st_d = FRPS_H_IO_ON;
        end
      end
      FRPS_H_IO_ON: begin
        st_d = FRPS_H_CORE_ON;
      end
      FRPS_H_CORE_ON: begin
        st_d = FRPS_H_WAIT;
      end
      FRPS_H_WAIT: begin
        if (cnt_q >= PVPERL_CYC - 1 && cnt_q >= PERST_CLK_CYC - 1) begin
          st_d = FRPS_H_RUN;
        end
      end
      FRPS_H_RUN: begin
        if (power_down_req) begin
          st_d = FRPS_H_DN_RST;
        end
      end
      FRPS_H_DN_RST: begin
        if (cnt_q >= PERST_CLK_CYC - 1) begin
          st_d = FRPS_H_DN_CORE;
        end
      end
      FRPS_H_DN_CORE: begin
        st_d = FRPS_H_OFF;
      end
      default: begin
        st_d = FRPS_H_OFF;
      end
    endcase
    // a rail out of range aborts straight into the power-off path
    if (powered && !rail_ok) begin
      st_d = FRPS_H_DN_RST;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= FRPS_H_OFF;
    end else begin
      st_q <= st_d;
    end
  end

  // restarts on every state change and while rails are still settling
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= '0;
    end else if (st_d != st_q || (st_q == FRPS_H_WAIT && !rail_ok)) begin
      cnt_q <= '0;
    end else if (cnt_q != 32'hffff_ffff) begin
      cnt_q <= cnt_q + 32'h0000_0001;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  logic perst_n_q;
  logic refclk_q;
  logic io_q;
  logic core_q;
  logic wake_q;

  // reset drops in the same edge the fault is seen, one cycle, far under the limit
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      perst_n_q <= 1'b0;
      refclk_q  <= 1'b0;
      io_q      <= 1'b0;
      core_q    <= 1'b0;
      wake_q    <= 1'b0;
    end else begin
      perst_n_q <= st_d == FRPS_H_RUN;
      refclk_q  <= core_up(st_d);
      io_q      <= st_d != FRPS_H_OFF;
      core_q    <= core_up(st_d);
      wake_q    <= ~dev.wake_n;
    end
  end

  assign dev.perst_n    = perst_n_q;
  assign dev.refclk_run = refclk_q;
  assign io_pwr_en      = io_q;
  assign core_pwr_en    = core_q;
  assign wake_seen      = wake_q;
  assign seq_state      = st_q;

endmodule : frps_host

/* frps_props.sv */
// frps_props.sv: checker for the wires between platform and device ends
// assumes it sits beside the frps_if instance, fed on core_clk with nrst
`timescale 1ns/100ps
`include "frps_params.svh"
module frps_props #(
  parameter int unsigned PVPERL_CYC    = `FRPS_PVPERL_CYC,
  parameter int unsigned PERST_CLK_CYC = `FRPS_PERST_CLK_CYC
)(
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // link wires
  input wire logic perst_n,
  input wire logic refclk_run,
  input wire logic wake_drv_n,
  input wire logic wake_oe_n,
  input wire logic wake_n
);
  // ****************************************
  // helper counters
  // ****************************************
  int unsigned clk_on_cnt_q;
  int unsigned rst_lo_cnt_q;

  // clock-running span, measured up to the reset release
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) clk_on_cnt_q <= 0;
    else clk_on_cnt_q <= refclk_run ? clk_on_cnt_q + 1 : 0;
  end

  // reset-held span, measured up to the clock stop
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) rst_lo_cnt_q <= 0;
    else rst_lo_cnt_q <= !perst_n ? rst_lo_cnt_q + 1 : 0;
  end

  // ****************************************
  // properties
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  AST_PWR_STABLE_WAIT: assert property ($rose(perst_n) |-> clk_on_cnt_q >= PVPERL_CYC)
    else $error("reset released before power settle time");
  AST_CLK_BEFORE_REL: assert property ($rose(perst_n) |-> clk_on_cnt_q >= PERST_CLK_CYC)
    else $error("reset released before clock settle time");
  AST_NO_REL_WO_CLK: assert property (!refclk_run |-> !perst_n)
    else $error("reset released with clock stopped");
  AST_CLK_START_HOLD: assert property ($rose(refclk_run) |-> !perst_n [*8])
    else $error("reset not held after clock start");
  AST_CLK_STOP_LATE: assert property ($fell(refclk_run) |-> rst_lo_cnt_q >= PERST_CLK_CYC)
    else $error("clock stopped too soon after reset");
  AST_CLK_RUNS_ON: assert property ($fell(perst_n) |-> refclk_run [*8])
    else $error("clock not kept after reset assert");
  AST_WAKE_DRIVES_LOW: assert property (!wake_oe_n |-> !wake_drv_n && !wake_n)
    else $error("wake enabled but not low");
  AST_WAKE_MIN_WIDTH: assert property ($fell(wake_oe_n) |=> !wake_oe_n)
    else $error("wake pulse shorter than two cycles");
endmodule : frps_props

/* test_fundamental_reset_power_seq.sv */
// test_fundamental_reset_power_seq.sv: joins both ends and walks power states
// assumes frps_params.svh in the include path; short waits via parameters
`timescale 1ns/100ps
module test_fundamental_reset_power_seq
  import frps_pkg::*;
;
  localparam int unsigned PV     = 40;
  localparam int unsigned PC     = 8;
  localparam int          WD_CYC = 4000;

  // ****************************************
  // signals
  // ****************************************
  logic         core_clk, nrst, d_state_wr, aspm_en, link_idle, turn_off_req;
  logic         sticky_wr, power_event_request_n, pm_msg_ready;
  logic         power_up_req, power_down_req, rail_ok;
  logic [1:0]   d_state_req;
  logic [7:0]   sticky_wdata, sticky_rdata;
  logic         pm_msg_valid, core_rst_n, pci_rst_n, io_pwr_en, core_pwr_en, wake_seen;
  frps_dstate_t d_state;
  frps_lstate_t link_state;
  frps_bstate_t bus_state;
  frps_hstate_t seq_state;
  int           n_errors, checks_done, i;

  frps_if frps_if_inst ();

  frps_dev frps_dev_inst (.core_clk(core_clk), .nrst(nrst), .plat(frps_if_inst),
    .d_state_wr(d_state_wr), .d_state_req(d_state_req), .aspm_en(aspm_en),
    .link_idle(link_idle), .turn_off_req(turn_off_req), .sticky_wr(sticky_wr),
    .sticky_wdata(sticky_wdata), .sticky_rdata(sticky_rdata),
    .power_event_request_n(power_event_request_n), .pm_msg_valid(pm_msg_valid),
    .pm_msg_ready(pm_msg_ready), .core_rst_n(core_rst_n), .pci_rst_n(pci_rst_n),
    .d_state(d_state), .link_state(link_state), .bus_state(bus_state));

  frps_host #(.PVPERL_CYC(PV), .PERST_CLK_CYC(PC)) frps_host_inst (.core_clk(core_clk),
    .nrst(nrst), .dev(frps_if_inst), .power_up_req(power_up_req),
    .power_down_req(power_down_req), .rail_ok(rail_ok), .io_pwr_en(io_pwr_en),
    .core_pwr_en(core_pwr_en), .wake_seen(wake_seen), .seq_state(seq_state));

  frps_props #(.PVPERL_CYC(PV), .PERST_CLK_CYC(PC)) frps_props_inst (.core_clk(core_clk),
    .nrst(nrst), .perst_n(frps_if_inst.perst_n), .refclk_run(frps_if_inst.refclk_run),
    .wake_drv_n(frps_if_inst.wake_drv_n), .wake_oe_n(frps_if_inst.wake_oe_n),
    .wake_n(frps_if_inst.wake_n));

  // ****************************************
  // tasks
  // ****************************************
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic set_dstate(input logic [1:0] code);
    @(posedge core_clk); d_state_wr <= 1'b1; d_state_req <= code;
    @(posedge core_clk); d_state_wr <= 1'b0;
  endtask : set_dstate

  // falling edge needs a sampled high first
  task automatic pme_req();
    @(posedge core_clk); power_event_request_n <= 1'b0;
    @(posedge core_clk); power_event_request_n <= 1'b1;
  endtask : pme_req

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_of_test

  // ****************************************
  // clock, watchdog
  // ****************************************
  always #2.5 core_clk = ~core_clk;

  initial begin
    #(WD_CYC * 5);
    n_errors++;
    end_of_test();
  end

  // ****************************************
  // sequence
  // ****************************************
  initial begin
    core_clk = 1'b0; nrst = 1'b0; d_state_wr = 1'b0; d_state_req = 2'h0; aspm_en = 1'b0;
    link_idle = 1'b0; turn_off_req = 1'b0; sticky_wr = 1'b0; sticky_wdata = 8'h00;
    power_event_request_n = 1'b1; pm_msg_ready = 1'b0; power_up_req = 1'b0;
    power_down_req = 1'b0; rail_ok = 1'b1; n_errors = 0; checks_done = 0;
    repeat (5) @(posedge core_clk);
    nrst <= 1'b1;
    @(negedge core_clk);
    chk("core reset", 8'h00, core_rst_n);
    chk("bus reset", 8'h00, pci_rst_n);
    chk("link", FRPS_L3, link_state);
    chk("bus", FRPS_B3, bus_state);
    $display("test reset done");

    @(posedge core_clk); power_up_req <= 1'b1;
    @(posedge core_clk); power_up_req <= 1'b0;
    for (i = 0; i < 6 && frps_if_inst.refclk_run !== 1'b1; i++) @(negedge core_clk);
    for (i = 0; i < PV + 8 && frps_if_inst.perst_n !== 1'b1; i++) @(negedge core_clk);
    chk("release wait", 8'h01, i >= PV);
    chk("clock on", 8'h01, frps_if_inst.refclk_run);
    repeat (2) @(negedge core_clk);
    chk("core reset hold", 8'h00, core_rst_n);
    @(negedge core_clk);
    chk("core reset end", 8'h01, core_rst_n);
    chk("bus reset hold", 8'h00, pci_rst_n);
    @(negedge core_clk);
    chk("bus reset end", 8'h01, pci_rst_n);
    for (i = 0; i < 4 && link_state !== FRPS_L0; i++) @(negedge core_clk);
    chk("link up", FRPS_L0, link_state);
    chk("d state", FRPS_D0, d_state);
    chk("host run", FRPS_H_RUN, seq_state);
    $display("test power up done");

    @(posedge core_clk); sticky_wr <= 1'b1; sticky_wdata <= 8'h5a;
    @(posedge core_clk); sticky_wr <= 1'b0;
    @(negedge core_clk);
    chk("sticky", 8'h5a, sticky_rdata);
    pme_req();
    for (i = 0; i < 4 && pm_msg_valid !== 1'b1; i++) @(negedge core_clk);
    repeat (4) @(negedge core_clk);
    chk("message held", 8'h01, pm_msg_valid);
    @(posedge core_clk); pm_msg_ready <= 1'b1;
    @(negedge core_clk);
    chk("message before take", 8'h01, pm_msg_valid);
    @(negedge core_clk);
    chk("message taken", 8'h00, pm_msg_valid);
    $display("test message done");

    @(posedge core_clk); aspm_en <= 1'b1; link_idle <= 1'b1;
    repeat (50) @(negedge core_clk);
    chk("idle early", FRPS_L0, link_state);
    for (i = 0; i < 40 && link_state !== FRPS_L0S; i++) @(negedge core_clk);
    chk("standby", FRPS_L0S, link_state);
    for (i = 0; i < 1100 && link_state !== FRPS_L1; i++) @(negedge core_clk);
    chk("low power", FRPS_L1, link_state);
    for (i = 0; i < 3 && bus_state !== FRPS_B1; i++) @(negedge core_clk);
    chk("bus low", FRPS_B1, bus_state);
    @(posedge core_clk); link_idle <= 1'b0; aspm_en <= 1'b0;
    for (i = 0; i < 4 && link_state !== FRPS_L0; i++) @(negedge core_clk);
    chk("link back", FRPS_L0, link_state);
    @(negedge core_clk);
    chk("bus up", FRPS_B0, bus_state);
    $display("test active link power done");

    set_dstate(2'h1);
    repeat (2) @(negedge core_clk);
    chk("d1 refused", FRPS_D0, d_state);
    set_dstate(2'h3);
    for (i = 0; i < 4 && bus_state !== FRPS_B2; i++) @(negedge core_clk);
    chk("d3 hot", FRPS_D3HOT, d_state);
    chk("bus d3", FRPS_B2, bus_state);
    @(posedge core_clk); turn_off_req <= 1'b1;
    @(posedge core_clk); turn_off_req <= 1'b0;
    for (i = 0; i < 4 && link_state !== FRPS_L23RDY; i++) @(negedge core_clk);
    chk("ready off", FRPS_L23RDY, link_state);
    pme_req();
    for (i = 0; i < 6 && wake_seen !== 1'b1; i++) @(negedge core_clk);
    chk("wake", 8'h00, frps_if_inst.wake_n);
    chk("wake seen", 8'h01, wake_seen);
    chk("no message", 8'h00, pm_msg_valid);
    $display("test d states done");

    @(posedge core_clk); power_down_req <= 1'b1;
    for (i = 0; i < 6 && frps_if_inst.perst_n !== 1'b0; i++) @(negedge core_clk);
    chk("core reset now", 8'h00, core_rst_n);
    chk("cold", FRPS_D3COLD, d_state);
    @(posedge core_clk); power_down_req <= 1'b0;
    for (i = 1; i < 30 && frps_if_inst.refclk_run !== 1'b0; i++) @(negedge core_clk);
    chk("clock stop wait", 8'h01, i >= PC);
    chk("core off", 8'h00, core_pwr_en);
    chk("io after core", 8'h01, io_pwr_en);
    @(negedge core_clk);
    chk("io off", 8'h00, io_pwr_en);
    chk("link off", FRPS_L3, link_state);
    for (i = 0; i < 200 && frps_if_inst.perst_n !== 1'b1; i++) @(negedge core_clk);
    chk("wake power up", 8'h01, frps_if_inst.perst_n);
    for (i = 0; i < 30 && frps_if_inst.wake_n !== 1'b1; i++) @(negedge core_clk);
    chk("wake cleared", 8'h01, frps_if_inst.wake_n);
    chk("sticky kept", 8'h5a, sticky_rdata);
    $display("test power cycle done");

    // rail fault: reset must follow well inside the failure limit
    @(posedge core_clk); rail_ok <= 1'b0;
    repeat (2) @(negedge core_clk);
    chk("fault reset", 8'h00, frps_if_inst.perst_n);
    chk("fault core", 8'h00, core_rst_n);
    for (i = 0; i < 30 && core_pwr_en !== 1'b0; i++) @(negedge core_clk);
    chk("host down", FRPS_H_DN_CORE, seq_state);
    @(posedge core_clk); rail_ok <= 1'b1;
    @(negedge core_clk);
    chk("host off", FRPS_H_OFF, seq_state);
    $display("test fault done");
    end_of_test();
  end
endmodule : test_fundamental_reset_power_seq
